//--- verilog/serial_output_advancement.sv
// Added by the designer: the Avalon-MM slave port.
`timescale 1ns/1ps
// Notes on behaviour
// - Thirty-two Local shift registers at indices 0x83 to 0xa2, one per stream.
// - Thirty-two Backplane shift registers at indices 0xa3 to 0xc2, one per stream.
// - Below 32 Mbps all 32 registers act; at 32 Mbps only 0 to 15.
// - Sixteen-bit register, code in bits 1:0, upper bits reserved zero, resets zero.
// - Below 32 Mbps codes 0..3 advance output by 0, 2, 4, 6 cycles.
// - At 32 Mbps codes 0..3 advance output by 0, 1, 2, 3 cycles.
// - Advancement counts system clock cycles, not stream clock cycles.
// - Code zero keeps the stream aligned with the generated frame pulse.
// - Each stream follows its own register independently of the others.
// - Backplane registers share field, codes and cycle counts with Local ones.
module serial_output_advancement (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Avalon-MM slave
  input wire logic [adv_pkg::ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [adv_pkg::DATA_W-1:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [adv_pkg::DATA_W-1:0] readdata,
  output logic waitrequest,
  // Core side, same clock, early by the largest advancement
  input wire logic frame_start_in,
  input wire logic local_rate_32m,
  input wire logic backplane_rate_32m,
  input wire logic [adv_pkg::NUM_STREAMS-1:0] local_stream_in,
  input wire logic [adv_pkg::NUM_STREAMS-1:0] backplane_stream_in,
  // Serial outputs
  output logic [adv_pkg::NUM_STREAMS-1:0] local_serial_out,
  output logic [adv_pkg::NUM_STREAMS-1:0] backplane_serial_out,
  output logic generated_frame_pulse
);
  import adv_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Address decode

  logic [IDX_W-1:0] reg_idx;
  logic local_hit;
  logic back_hit;
  logic [STREAM_W-1:0] local_stream;
  logic [STREAM_W-1:0] back_stream;
  logic code_lane;

  assign reg_idx = address[IDX_LSB +: IDX_W];
  assign local_hit = idx_in_range(reg_idx, LOCAL_FIRST_IDX, LOCAL_LAST_IDX);
  assign back_hit = idx_in_range(reg_idx, BACK_FIRST_IDX, BACK_LAST_IDX);
  assign local_stream = stream_of(reg_idx, LOCAL_FIRST_IDX);
  assign back_stream = stream_of(reg_idx, BACK_FIRST_IDX);
  assign code_lane = byteenable[CODE_BYTE];

  ////////////////////////////////////////////////////////////////////////
  // Bus handshake: every access answers on the second edge

  bus_state_type state_reg;
  bus_state_type state_next;
  logic waitrequest_reg;
  logic waitrequest_next;
  logic [DATA_W-1:0] readdata_reg;
  logic [DATA_W-1:0] readdata_next;
  logic do_write;
  logic [CODE_W-1:0] wr_code;

  port_shift_if local_cfg ();
  port_shift_if back_cfg ();

  // Write lands on the edge where waitrequest is seen low
  assign do_write = (state_reg == BUS_ANSWER) && write && code_lane;
  assign wr_code = writedata[CODE_LSB +: CODE_W];

  always_comb begin
    state_next = state_reg;
    waitrequest_next = 1'b1;
    readdata_next = readdata_reg;
    case (state_reg)
      BUS_IDLE: begin
        if (read || write) begin
          state_next = BUS_ANSWER;
          waitrequest_next = 1'b0;
          // Reserved bits read as zero; unmapped reads give zero
          if (local_hit) begin
            readdata_next = {{(DATA_W-CODE_W){1'b0}}, local_cfg.live[local_stream]};
          end else if (back_hit) begin
            readdata_next = {{(DATA_W-CODE_W){1'b0}}, back_cfg.live[back_stream]};
          end else begin
            readdata_next = READ_UNMAPPED;
          end
        end
      end
      BUS_ANSWER: begin
        state_next = BUS_IDLE;
      end
      default: begin
        state_next = BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= BUS_IDLE;
      waitrequest_reg <= 1'b1;
      readdata_reg <= '0;
    end else begin
      state_reg <= state_next;
      waitrequest_reg <= waitrequest_next;
      readdata_reg <= readdata_next;
    end
  end

  assign waitrequest = waitrequest_reg;
  assign readdata = readdata_reg;

  ////////////////////////////////////////////////////////////////////////
  // Per-port code storage

  shift_store local_store (
    .clk(clk),
    .rst(rst),
    .wr_en(do_write && local_hit),
    .wr_stream(local_stream),
    .wr_code(wr_code),
    .frame_start(frame_start_in),
    .rate_32m(local_rate_32m),
    .cfg(local_cfg.store)
  );

  shift_store back_store (
    .clk(clk),
    .rst(rst),
    .wr_en(do_write && back_hit),
    .wr_stream(back_stream),
    .wr_code(wr_code),
    .frame_start(frame_start_in),
    .rate_32m(backplane_rate_32m),
    .cfg(back_cfg.store)
  );

  ////////////////////////////////////////////////////////////////////////
  // Delay lines

  stream_advance local_adv (
    .clk(clk),
    .rst(rst),
    .serial_in(local_stream_in),
    .cfg(local_cfg.apply),
    .serial_out(local_serial_out)
  );

  stream_advance back_adv (
    .clk(clk),
    .rst(rst),
    .serial_in(backplane_stream_in),
    .cfg(back_cfg.apply),
    .serial_out(backplane_serial_out)
  );

  ////////////////////////////////////////////////////////////////////////
  // Frame pulse, delayed to match a stream at code zero

  logic [MAX_ADV:0] fp_line_reg;
  logic fp_out_reg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fp_line_reg <= '0;
      fp_out_reg <= 1'b0;
    end else begin
      fp_line_reg <= {fp_line_reg[MAX_ADV-1:0], frame_start_in};
      fp_out_reg <= fp_line_reg[MAX_ADV];
    end
  end

  assign generated_frame_pulse = fp_out_reg;

endmodule : serial_output_advancement

//--- verilog/adv_pkg.sv
package adv_pkg;

  localparam int NUM_STREAMS = 32;
  localparam int NUM_STREAMS_32M = 16;
  localparam int CODE_W = 2;
  localparam int STREAM_W = 5;
  localparam int REG_W = 16;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 10;
  localparam int IDX_W = 8;
  localparam int IDX_LSB = 2;

  // Register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] LOCAL_FIRST_IDX = 8'h83;
  localparam logic [IDX_W-1:0] LOCAL_LAST_IDX = 8'ha2;
  localparam logic [IDX_W-1:0] BACK_FIRST_IDX = 8'ha3;
  localparam logic [IDX_W-1:0] BACK_LAST_IDX = 8'hc2;

  localparam int CODE_LSB = 0;
  localparam logic [CODE_W-1:0] CODE_RESET = 2'h0;
  localparam logic [DATA_W-1:0] READ_UNMAPPED = 32'h0;
  localparam int CODE_BYTE = 0;

  // Advancement in system clock cycles
  localparam int MAX_ADV = 6;
  localparam int TAP_W = 3;
  localparam logic [TAP_W-1:0] MAX_ADV_TAP = 3'h6;
  localparam logic UNUSED_LEVEL = 1'b1;

  typedef enum {BUS_IDLE, BUS_ANSWER} bus_state_type;

  function automatic logic idx_in_range(input logic [IDX_W-1:0] idx, input logic [IDX_W-1:0] first,
                                        input logic [IDX_W-1:0] last);
    idx_in_range = (idx >= first) && (idx <= last);
  endfunction : idx_in_range

  function automatic logic [STREAM_W-1:0] stream_of(input logic [IDX_W-1:0] idx,
                                                   input logic [IDX_W-1:0] first);
    logic [IDX_W-1:0] diff;
    diff = idx - first;
    stream_of = diff[STREAM_W-1:0];
  endfunction : stream_of

  // Step of two cycles below 32 Mbps, one cycle at 32 Mbps
  function automatic logic [TAP_W-1:0] adv_cycles(input logic [CODE_W-1:0] code, input logic is_32m);
    adv_cycles = is_32m ? {1'b0, code} : {code, 1'b0};
  endfunction : adv_cycles

endpackage : adv_pkg

//--- verilog/port_shift_if.sv
`timescale 1ns/1ps
interface port_shift_if;
  import adv_pkg::*;
  logic [NUM_STREAMS-1:0][CODE_W-1:0] live;
  logic [NUM_STREAMS-1:0][CODE_W-1:0] active;
  logic mode_32m;
  modport store (output live, output active, output mode_32m);
  modport apply (input active, input mode_32m);
  modport host (input live);
endinterface : port_shift_if

//--- verilog/shift_store.sv
`timescale 1ns/1ps
module shift_store (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register write
  input wire logic wr_en,
  input wire logic [adv_pkg::STREAM_W-1:0] wr_stream,
  input wire logic [adv_pkg::CODE_W-1:0] wr_code,
  // Frame timing and port rate
  input wire logic frame_start,
  input wire logic rate_32m,
  // Codes toward the delay lines
  port_shift_if.store cfg
);
  import adv_pkg::*;

  logic [NUM_STREAMS-1:0][CODE_W-1:0] live_reg;
  logic [NUM_STREAMS-1:0][CODE_W-1:0] active_reg;
  logic mode_32m_reg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      live_reg <= '0;
    end else if (wr_en) begin
      live_reg[wr_stream] <= wr_code;
    end
  end

  // Applied only at the frame boundary so no bit period is cut short
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      active_reg <= '0;
      mode_32m_reg <= 1'b0;
    end else if (frame_start) begin
      active_reg <= live_reg;
      mode_32m_reg <= rate_32m;
    end
  end

  assign cfg.live = live_reg;
  assign cfg.active = active_reg;
  assign cfg.mode_32m = mode_32m_reg;

endmodule : shift_store

//--- verilog/stream_advance.sv
`timescale 1ns/1ps
module stream_advance (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Streams from the core, early by the largest advancement
  input wire logic [adv_pkg::NUM_STREAMS-1:0] serial_in,
  // Codes in force
  port_shift_if.apply cfg,
  // Shifted streams
  output logic [adv_pkg::NUM_STREAMS-1:0] serial_out
);
  import adv_pkg::*;

  logic [MAX_ADV:0][NUM_STREAMS-1:0] line_reg;
  logic [NUM_STREAMS-1:0] tap;
  logic [NUM_STREAMS-1:0] out_reg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      line_reg <= '0;
    end else begin
      line_reg <= {line_reg[MAX_ADV-1:0], serial_in};
    end
  end

  // Less delay means more advancement against the frame pulse
  genvar s;
  generate
    for (s = 0; s < NUM_STREAMS; s++) begin : g_tap
      logic [TAP_W-1:0] depth;
      assign depth = MAX_ADV_TAP - adv_cycles(cfg.active[s], cfg.mode_32m);
      if (s < NUM_STREAMS_32M) begin : g_low
        assign tap[s] = line_reg[depth][s];
      end else begin : g_high
        assign tap[s] = cfg.mode_32m ? UNUSED_LEVEL : line_reg[depth][s];
      end
    end
  endgenerate

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      out_reg <= '0;
    end else begin
      out_reg <= tap;
    end
  end

  assign serial_out = out_reg;

endmodule : stream_advance

//--- bench/adv_checker.sv
`timescale 1ns/1ps
module adv_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Bus
  input wire logic [adv_pkg::ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [adv_pkg::DATA_W-1:0] writedata,
  input wire logic [3:0] byteenable,
  input wire logic [adv_pkg::DATA_W-1:0] readdata,
  input wire logic waitrequest,
  // Frame timing
  input wire logic frame_start_in,
  input wire logic generated_frame_pulse
);
  import adv_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire logic mapped = (address[9:2] >= LOCAL_FIRST_IDX) && (address[9:2] <= BACK_LAST_IDX);
  logic [ADDR_W-1:0] wa_reg;
  logic [1:0] wc_reg;
  logic wv_reg;
  // Last stored write, for readback
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wv_reg <= 1'b0;
      wa_reg <= '0;
      wc_reg <= '0;
    end else if (write && !waitrequest && byteenable[0] && mapped) begin
      wv_reg <= 1'b1;
      wa_reg <= address;
      wc_reg <= writedata[1:0];
    end
  end
  sequence taken_s;
    (read || write) && waitrequest;
  endsequence
  sequence rd_done_s;
    read && !waitrequest;
  endsequence
  a_answer_next: assert property (taken_s |=> !waitrequest) else $error("no answer");
  a_wait_single: assert property (!waitrequest |=> waitrequest) else $error("long answer");
  a_no_spont: assert property (!(read || write) && waitrequest |=> waitrequest) else $error("spurious");
  a_unmapped_zero: assert property (read && waitrequest && !mapped |=> readdata == '0) else $error("unmapped");
  a_upper_zero: assert property (rd_done_s |-> readdata[31:2] == '0) else $error("reserved bits");
  a_read_back: assert property (rd_done_s ##0 (wv_reg && address == wa_reg) |-> readdata[1:0] == wc_reg)
    else $error("readback");
  a_pulse_delay: assert property (frame_start_in |-> ##8 generated_frame_pulse) else $error("pulse late");
  a_pulse_source: assert property (generated_frame_pulse |-> $past(frame_start_in, 8)) else $error("pulse extra");
  a_reset_idle: assert property ($fell(rst) |-> waitrequest && readdata == '0) else $error("reset state");
endmodule : adv_checker

bind serial_output_advancement adv_checker chk_u (.clk(clk), .rst(rst), .address(address), .read(read),
  .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
  .waitrequest(waitrequest), .frame_start_in(frame_start_in), .generated_frame_pulse(generated_frame_pulse));

//--- bench/stream_sink.sv
`timescale 1ns/1ps
module stream_sink (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Frame pulse from the switch
  input wire logic frame_rx,
  // Frames seen
  output int frames
);
  // Downstream part only frames itself; data is judged in the bench
  always_ff @(posedge clk or posedge rst) begin
    if (rst) frames <= 0;
    else if (frame_rx) frames <= frames + 1;
  end
endmodule : stream_sink

//--- bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import adv_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [ADDR_W-1:0] address = '0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [DATA_W-1:0] writedata = '0;
  logic [3:0] byteenable = 4'hf;
  logic [DATA_W-1:0] readdata, q;
  logic waitrequest, gfp;
  logic frame_start_in = 1'b0;
  logic [1:0] rate = 2'h0;
  logic [1:0] rate_app = 2'h0;
  logic [31:0] lin = '0;
  logic [31:0] bin = '0;
  logic [31:0] lout, bout;
  logic [1:0] live [2][32] = '{default: 2'h0};
  logic [1:0] app [2][32] = '{default: 2'h0};
  logic [31:0] hist [2][9];
  logic [8:0] fh = '0;
  int frames, cyc = 0, fs_count = 0;
  int bad_count = 0;
  int cmp_count = 0;

  always #4 clk = ~clk;

  serial_output_advancement dut_u (.clk(clk), .rst(rst), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
    .frame_start_in(frame_start_in), .local_rate_32m(rate[0]), .backplane_rate_32m(rate[1]),
    .local_stream_in(lin), .backplane_stream_in(bin), .local_serial_out(lout),
    .backplane_serial_out(bout), .generated_frame_pulse(gfp));
  stream_sink sink_u (.clk(clk), .rst(rst), .frame_rx(gfp), .frames(frames));

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic close_out;
    if (bad_count == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : close_out

  function automatic logic [31:0] expect_port(input int p);
    logic [31:0] r;
    int l;
    for (int n = 0; n < 32; n++) begin
      l = 8 - (rate_app[p] ? int'(app[p][n]) : 2 * app[p][n]);
      r[n] = (rate_app[p] && n >= 16) ? 1'b1 : hist[p][l][n];
    end
    return r;
  endfunction : expect_port

  function automatic logic [31:0] expect_reg(input int i);
    return (i >= 'h83 && i <= 'hc2) ? {30'h0, live[i >= 'ha3][(i - 'h83) % 32]} : 32'h0;
  endfunction : expect_reg

  // Holds the request until waitrequest is seen low, then idles one edge
  task automatic bus(input logic wr, input int i, input logic [31:0] d, input logic [3:0] be);
    int n;
    n = 0;
    address <= ADDR_W'(i * 4);
    read <= !wr;
    write <= wr;
    writedata <= d;
    byteenable <= be;
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 20);
    if (n >= 20) begin
      bad_count++;
      $display("BAD waitrequest expected %h seen %h", 1'b0, waitrequest);
    end
    q = readdata;
    if (wr && be[0] && i >= 'h83 && i <= 'hc2) live[i >= 'ha3][(i - 'h83) % 32] <= d[1:0];
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clk);
  endtask : bus

  ////////////////////////////////////////////////////////////////////////////
  // Masks the two cycles after a boundary, where old and new codes may meet
  always @(posedge clk) begin
    cyc <= cyc + 1;
    lin <= $urandom();
    bin <= $urandom();
    frame_start_in <= !rst && (cyc % 32 == 31);
    if (!rst) begin
      for (int i = 8; i > 0; i--) begin
        hist[0][i] = hist[0][i-1];
        hist[1][i] = hist[1][i-1];
      end
      hist[0][0] = lin;
      hist[1][0] = bin;
      fh = {fh[7:0], frame_start_in};
      if (cyc > 20 && fh[2:1] == 2'h0) begin
        check("local", lout, expect_port(0));
        check("backplane", bout, expect_port(1));
      end
      if (cyc > 20) check("pulse", {31'h0, gfp}, {31'h0, fh[8]});
      if (frame_start_in) begin
        fs_count++;
        app = live;
        rate_app = rate;
      end
    end
  end

  initial begin
    void'($urandom(74));
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int i = 'h82; i <= 'hc3; i++) begin
      bus(1'b0, i, 32'h0, 4'hf);
      check("reset", q, 32'h0);
    end
    for (int pass = 0; pass < 8; pass++) begin
      rate <= 2'(pass);
      for (int i = 'h82; i <= 'hc3; i++)
        bus(1'b1, i, {30'h0, pass >= 4 ? 2'(pass) : 2'($urandom_range(0, 3))},
          (pass < 4 && $urandom_range(0, 3) == 0) ? 4'he : 4'hf);
      for (int i = 'h82; i <= 'hc3; i++) begin
        bus(1'b0, i, 32'h0, 4'hf);
        check("readback", q, expect_reg(i));
      end
      repeat (70) @(posedge clk);
    end
    // Stop away from a frame start so no pulse is still in flight
    while (cyc % 32 != 16) @(posedge clk);
    check("frames", 32'(frames), 32'(fs_count));
    close_out();
  end

  initial begin
    #160000;
    bad_count++;
    $display("BAD watchdog expected finished seen timeout");
    close_out();
  end
endmodule : tb_top
